// file: valve_pos_pkg.sv
package valve_pos_pkg;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS = 4'hc;
  // Control register bits
  localparam int CMD_OPEN_BIT = 0;
  localparam int CMD_CLOSE_BIT = 1;
  localparam int CMD_STOP_BIT = 2;
  localparam int FAULT_ACK_BIT = 3;
  localparam int TC_TIE_BIT = 4;
  // Event bits, shared by status and mask
  localparam int EV_W = 4;
  localparam int EV_OPEN_END = 0;
  localparam int EV_CLOSE_END = 1;
  localparam int EV_BLOCKED = 2;
  localparam int EV_STOPPED = 3;
  // Status register fields
  localparam int STS_STATE_LSB = 0;
  localparam int STS_STATE_W = 3;
  localparam int STS_FAULT_BIT = 4;
  localparam int STS_OPENED_BIT = 5;
  localparam int STS_CLOSED_BIT = 6;
  localparam int STS_CONTACT_LSB = 8;
  localparam int STS_CONTACT_W = 4;
  localparam int STS_TIE_BIT = 12;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;
  localparam logic TIE_RST = 1'b0;
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int FLICK_HALF_US = 250;
  localparam int FLICK_HALF_CYC = (CLK_HZ / 1_000_000) * FLICK_HALF_US;

  typedef struct packed {
    logic torque_closed_contact;
    logic limit_closed_contact;
    logic limit_open_contact;
    logic torque_open_contact;
  } contacts_s;

  typedef struct packed {
    logic open_command;
    logic close_command;
    logic stop_command;
    logic fault_ack;
  } cmds_s;

  typedef enum logic [2:0] {
    idle_st,
    opening_st,
    closing_st,
    open_st,
    closed_st,
    stopped_st,
    blocked_st
  } pos_state_e;
endpackage

// file: contact_sync.sv
module contact_sync
  import valve_pos_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input valve_pos_pkg::contacts_s raw_i,
  output valve_pos_pkg::contacts_s sync_o
);
  contacts_s meta_r;
  contacts_s sync_r;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else if (ce_i)
    begin
      meta_r <= raw_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule

// file: flicker_gen.sv
module flicker_gen #(
  parameter int HALF_CYC = valve_pos_pkg::FLICK_HALF_CYC
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  output logic flick_o
);
  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);
  logic [CW-1:0] cnt_r;
  logic flick_r;

  // Square wave, one half period per count
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      cnt_r <= '0;
      flick_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (cnt_r == LAST)
      begin
        cnt_r <= '0;
        flick_r <= ~flick_r;
      end
      else
        cnt_r <= cnt_r + CW'(1);
    end
  end

  assign flick_o = flick_r;
endmodule

// file: valve_positioner.sv
// Summary of operation
// - Drive is removed once either end position is confirmed.
// - Opening ends when open limit closed and open torque contact opens.
// - Closing ends as soon as the closed limit contact closes.
// - Closing end decided by closed limit contact only, never torque.
// - Torque closed trip before closed limit stops drive, flags blocked.
// - Torque closed input tied to one never causes blocked fault.
// - Open lamp flickers while opening and open end not reached.
// - Close lamp flickers while closing and closed end not reached.
// - Stop between ends lights stop lamp steadily, both drives off.
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
module valve_positioner
  import valve_pos_pkg::*;
#(
  parameter int FLICK_CYC = valve_pos_pkg::FLICK_HALF_CYC
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic torque_closed_contact_i,
  input wire logic limit_closed_contact_i,
  input wire logic limit_open_contact_i,
  input wire logic torque_open_contact_i,
  output logic motor_open_o,
  output logic motor_close_o,
  output logic open_lamp_out_o,
  output logic close_lamp_out_o,
  output logic stop_lamp_out_o,
  output logic opened_status_flag_o,
  output logic closed_status_flag_o,
  output logic irq_o
);
  import valve_pos_pkg::*;

  contacts_s raw;
  contacts_s ctc;
  cmds_s cmd;
  pos_state_e state_r;
  pos_state_e state_nxt;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] irq_stat_r;
  logic [EV_W-1:0] irq_mask_r;
  logic tie_r;
  logic tc_eff;
  logic flick;
  logic wait_r;
  logic [31:0] rdata_r;
  logic wr_ok;
  logic wr_lo;
  logic [31:0] rd_val;
  logic motor_open_r;
  logic motor_close_r;
  logic open_lamp_r;
  logic close_lamp_r;
  logic stop_lamp_r;
  logic opened_r;
  logic closed_r;
  logic irq_r;

  assign raw = '{torque_closed_contact: torque_closed_contact_i,
                 limit_closed_contact: limit_closed_contact_i,
                 limit_open_contact: limit_open_contact_i,
                 torque_open_contact: torque_open_contact_i};

  contact_sync u_sync (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .raw_i(raw),
    .sync_o(ctc)
  );

  flicker_gen #(
    .HALF_CYC(FLICK_CYC)
  ) u_flick (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .flick_o(flick)
  );

  assign tc_eff = ctc.torque_closed_contact | tie_r;

  // Bus request accepted on the cycle waitrequest is low
  assign wr_ok = avs_write_i && !wait_r;
  assign wr_lo = wr_ok && avs_byteenable_i[0];

  always_comb
  begin
    cmd = '0;
    if (wr_lo && avs_address_i == CTRL_OFS)
    begin
      cmd.open_command = avs_writedata_i[CMD_OPEN_BIT];
      cmd.close_command = avs_writedata_i[CMD_CLOSE_BIT];
      cmd.stop_command = avs_writedata_i[CMD_STOP_BIT];
      cmd.fault_ack = avs_writedata_i[FAULT_ACK_BIT];
    end
  end

  // Positioner sequencing
  always_comb
  begin
    state_nxt = state_r;
    ev = '0;
    unique case (state_r)
      blocked_st:
        if (cmd.fault_ack)
          state_nxt = idle_st;
      opening_st:
        // open end judged by limit and torque in the same cycle
        if (ctc.limit_open_contact && !ctc.torque_open_contact)
        begin
          state_nxt = open_st;
          ev[EV_OPEN_END] = 1'b1;
        end
        else if (cmd.stop_command)
        begin
          state_nxt = stopped_st;
          ev[EV_STOPPED] = 1'b1;
        end
        else if (cmd.close_command)
          state_nxt = closing_st;
      closing_st:
        // torque contacts not used for end
        if (ctc.limit_closed_contact)
        begin
          state_nxt = closed_st;
          ev[EV_CLOSE_END] = 1'b1;
        end
        else if (!tc_eff)
        begin
          state_nxt = blocked_st;
          ev[EV_BLOCKED] = 1'b1;
        end
        else if (cmd.stop_command)
        begin
          state_nxt = stopped_st;
          ev[EV_STOPPED] = 1'b1;
        end
        else if (cmd.open_command)
          state_nxt = opening_st;
      idle_st, stopped_st, open_st, closed_st:
        if (cmd.open_command && state_r != open_st)
          state_nxt = opening_st;
        else if (cmd.close_command && state_r != closed_st)
          state_nxt = closing_st;
        else if (cmd.stop_command && state_r == idle_st)
        begin
          state_nxt = stopped_st;
          ev[EV_STOPPED] = 1'b1;
        end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      state_r <= idle_st;
    else if (ce_i)
      state_r <= state_nxt;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      motor_open_r <= 1'b0;
      motor_close_r <= 1'b0;
      opened_r <= 1'b0;
      closed_r <= 1'b0;
      stop_lamp_r <= 1'b0;
    end
    else if (ce_i)
    begin
      motor_open_r <= state_nxt == opening_st;
      motor_close_r <= state_nxt == closing_st;
      opened_r <= state_nxt == open_st;
      closed_r <= state_nxt == closed_st;
      stop_lamp_r <= state_nxt == stopped_st;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      open_lamp_r <= 1'b0;
    else if (ce_i)
      open_lamp_r <= (state_r == opening_st) && flick;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      close_lamp_r <= 1'b0;
    else if (ce_i)
      close_lamp_r <= (state_r == closing_st) && flick;
  end

  // Control bit and interrupt registers
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      tie_r <= TIE_RST;
      irq_mask_r <= EV_RST;
      irq_stat_r <= EV_RST;
    end
    else if (ce_i)
    begin
      if (wr_lo && avs_address_i == CTRL_OFS)
        tie_r <= avs_writedata_i[TC_TIE_BIT];
      if (wr_lo && avs_address_i == IRQ_MASK_OFS)
        irq_mask_r <= avs_writedata_i[EV_W-1:0];
      if (wr_lo && avs_address_i == IRQ_STAT_OFS)
        irq_stat_r <= (irq_stat_r & ~avs_writedata_i[EV_W-1:0]) | ev;
      else
        irq_stat_r <= irq_stat_r | ev;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      irq_r <= 1'b0;
    else if (ce_i)
      irq_r <= |(irq_stat_r & irq_mask_r);
  end

  always_comb
  begin
    rd_val = '0;
    unique case (avs_address_i)
      CTRL_OFS:
        rd_val[TC_TIE_BIT] = tie_r;
      STATUS_OFS:
      begin
        rd_val[STS_STATE_LSB +: STS_STATE_W] = state_r;
        rd_val[STS_FAULT_BIT] = state_r == blocked_st;
        rd_val[STS_OPENED_BIT] = opened_r;
        rd_val[STS_CLOSED_BIT] = closed_r;
        rd_val[STS_CONTACT_LSB +: STS_CONTACT_W] = ctc;
        rd_val[STS_TIE_BIT] = tie_r;
      end
      IRQ_STAT_OFS:
        rd_val[EV_W-1:0] = irq_stat_r;
      IRQ_MASK_OFS:
        rd_val[EV_W-1:0] = irq_mask_r;
      default:
        rd_val = '0;
    endcase
  end

  // One wait cycle, then answer for one cycle
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      wait_r <= 1'b1;
      rdata_r <= '0;
    end
    else if (ce_i)
    begin
      if ((avs_read_i || avs_write_i) && wait_r)
      begin
        wait_r <= 1'b0;
        rdata_r <= rd_val;
      end
      else
        wait_r <= 1'b1;
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign motor_open_o = motor_open_r;
  assign motor_close_o = motor_close_r;
  assign open_lamp_out_o = open_lamp_r;
  assign close_lamp_out_o = close_lamp_r;
  assign stop_lamp_out_o = stop_lamp_r;
  assign opened_status_flag_o = opened_r;
  assign closed_status_flag_o = closed_r;
  assign irq_o = irq_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  a_open_end_stop: assert property (
    state_r == opening_st && ce_i && ctc.limit_open_contact &&
    !ctc.torque_open_contact |=> state_r == open_st && !motor_open_o)
    else $error("open end not taken");

  a_close_end_stop: assert property (
    state_r == closing_st && ce_i && ctc.limit_closed_contact
    |=> state_r == closed_st && !motor_close_o && closed_status_flag_o)
    else $error("closed end not taken");

  a_close_limit_only: assert property (
    state_r == closing_st && ce_i && !ctc.limit_closed_contact
    |=> state_r != closed_st)
    else $error("closed end without limit");

  a_blocked_trip: assert property (
    state_r == closing_st && ce_i && !ctc.limit_closed_contact && !tc_eff
    |=> state_r == blocked_st && !motor_close_o)
    else $error("blocked fault missed");

  a_tie_no_fault: assert property (
    tie_r && state_r == closing_st && ce_i |=> state_r != blocked_st)
    else $error("blocked with tied torque input");

  a_open_lamp_flick: assert property (
    state_r == opening_st && ce_i |=> open_lamp_out_o == $past(flick))
    else $error("open lamp not flickering");

  a_close_lamp_flick: assert property (
    state_r == closing_st && ce_i |=> close_lamp_out_o == $past(flick))
    else $error("close lamp not flickering");

  a_stop_lamp_on: assert property (
    state_r == stopped_st |-> stop_lamp_out_o && !motor_open_o &&
    !motor_close_o)
    else $error("stop lamp or drive wrong");

  a_fault_latch_hold: assert property (
    state_r == blocked_st && !cmd.fault_ack |=> state_r == blocked_st &&
    !motor_open_o && !motor_close_o)
    else $error("blocked fault lost");

  a_irq_level_out: assert property (
    ce_i |=> irq_o == |($past(irq_stat_r) & $past(irq_mask_r)))
    else $error("interrupt level wrong");
endmodule

// file: actuator_model.sv
module actuator_model
  import valve_pos_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic motor_open_i,
  input wire logic motor_close_i,
  input wire logic slow_i,
  input wire logic jam_i,
  output valve_pos_pkg::contacts_s sw_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] pos_r;
  logic [1:0] div_r;
  // Travel, one step a cycle or a quarter of that
  always_ff @(posedge mclk_i)
  begin
    div_r <= div_r + 2'h1;
    if (srst_i)
    begin
      pos_r <= 6'h14;
      div_r <= 2'h0;
    end
    else if (!slow_i || div_r == 2'h0)
    begin
      if (motor_open_i && pos_r < 6'h28)
        pos_r <= pos_r + 6'h1;
      else if (motor_close_i && pos_r > 6'h0)
        pos_r <= pos_r - 6'h1;
    end
  end
  always_comb
  begin
    sw_o.limit_open_contact = pos_r >= 6'h23;
    sw_o.torque_open_contact = pos_r < 6'h28;
    sw_o.limit_closed_contact = pos_r <= 6'h05;
    sw_o.torque_closed_contact = pos_r != 6'h0 && !jam_i;
  end
endmodule

// file: valve_positioner_test.sv
module valve_positioner_test;
  timeunit 1ns;
  timeprecision 1ns;
  import valve_pos_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic slow = 1'b0;
  logic jam = 1'b0;
  logic [31:0] rdat, rv, r;
  logic [31:0] seed = 32'h1b33157d;
  logic wreq, m_op, m_cl, l_op, l_cl, l_st, f_op, f_cl, irq;
  contacts_s sw;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int hi;

  valve_positioner #(.FLICK_CYC(4)) DUT (
    .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(1'b1),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .torque_closed_contact_i(sw.torque_closed_contact),
    .limit_closed_contact_i(sw.limit_closed_contact),
    .limit_open_contact_i(sw.limit_open_contact),
    .torque_open_contact_i(sw.torque_open_contact),
    .motor_open_o(m_op), .motor_close_o(m_cl),
    .open_lamp_out_o(l_op), .close_lamp_out_o(l_cl),
    .stop_lamp_out_o(l_st), .opened_status_flag_o(f_op),
    .closed_status_flag_o(f_cl), .irq_o(irq)
  );

  actuator_model pm (
    .mclk_i(mclk_i), .srst_i(srst_i), .motor_open_i(m_op),
    .motor_close_i(m_cl), .slow_i(slow), .jam_i(jam), .sw_o(sw)
  );

  initial
  begin
    forever #4 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do
      @(posedge mclk_i);
    while (wreq !== 1'b0);
    rv = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task wait_st(input logic [2:0] s);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, STATUS_OFS, 32'h0);
      n++;
    end
    while (rv[2:0] !== s && n < 100);
    check(rv[2:0], s);
  endtask

  task lamp(input int sel, output int h);
    h = 0;
    repeat (16)
    begin
      @(posedge mclk_i);
      #1;
      h += (sel == 0) ? l_op : (sel == 1) ? l_cl : l_st;
    end
  endtask

  initial
  begin
    repeat (6) @(posedge mclk_i);
    srst_i <= 1'b0;
    #1;
    check({m_op, m_cl, l_op, l_cl, l_st, f_op, f_cl, irq, wreq}, 9'h001);
    bus(1'b0, IRQ_MASK_OFS, 32'h0);
    check(rv, 32'h0);
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    check(rv, 32'h0);
    bus(1'b0, STATUS_OFS, 32'h0);
    check(rv, 32'h0900); // synced contacts
    bus(1'b0, 4'h2, 32'h0);
    check(rv, 32'h0);
    r = lfsr(seed);
    seed = r;
    bus(1'b1, IRQ_MASK_OFS, r);
    bus(1'b0, IRQ_MASK_OFS, 32'h0);
    check(rv, {28'h0, r[3:0]});
    bus(1'b1, IRQ_MASK_OFS, 32'h0);
    be <= 4'he;
    bus(1'b1, CTRL_OFS, 32'h1);
    be <= 4'hf;
    #1;
    check(m_op, 1'b0);
    $display("done: reset and refusals");
    bus(1'b1, CTRL_OFS, 32'h1);
    #1;
    check(m_op, 1'b1); // drive while opening
    lamp(0, hi);
    check(hi > 4 && hi < 12, 1'b1); // open lamp flickers
    wait_st(open_st); // open end
    check({m_op, f_op, l_op, irq}, 4'b0100); // drive off
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    check(rv[3:0], 4'h1); // end event
    bus(1'b1, IRQ_MASK_OFS, 32'h1);
    repeat (2) @(posedge mclk_i);
    #1;
    check(irq, 1'b1);
    bus(1'b1, IRQ_STAT_OFS, 32'h1);
    repeat (2) @(posedge mclk_i);
    #1;
    check(irq, 1'b0);
    $display("done: open travel");
    bus(1'b1, CTRL_OFS, 32'h2);
    #1;
    check({m_op, m_cl}, 2'b01); // drive while closing
    lamp(1, hi);
    check(hi > 4 && hi < 12, 1'b1); // close lamp flickers
    wait_st(closed_st); // closed end
    check({m_cl, f_cl, sw.torque_closed_contact}, 3'b011); // limit only
    bus(1'b1, IRQ_STAT_OFS, 32'hf);
    $display("done: close travel");
    r = lfsr(seed);
    seed = r;
    slow <= r[0];
    bus(1'b1, CTRL_OFS, 32'h1);
    repeat (8 + r[4:1]) @(posedge mclk_i);
    bus(1'b1, CTRL_OFS, 32'h4);
    wait_st(stopped_st); // stop between ends
    lamp(2, hi);
    check(hi, 16); // steady stop lamp
    check({m_op, m_cl, l_op, l_cl}, 4'h0); // drives off
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    check(rv[3:0], 4'h8); // stop event
    bus(1'b1, IRQ_STAT_OFS, 32'hf);
    bus(1'b1, IRQ_MASK_OFS, 32'h4);
    $display("done: stop");
    jam <= 1'b1;
    bus(1'b1, CTRL_OFS, 32'h2);
    wait_st(blocked_st); // early torque trip
    check({rv[4], m_cl, irq}, 3'b101); // fault flagged
    bus(1'b1, CTRL_OFS, 32'h1);
    #1;
    check(m_op, 1'b0); // latched fault
    jam <= 1'b0;
    bus(1'b1, CTRL_OFS, 32'h8);
    wait_st(idle_st); // acknowledge clears
    bus(1'b1, IRQ_STAT_OFS, 32'hf);
    $display("done: blocked");
    jam <= 1'b1;
    bus(1'b1, CTRL_OFS, 32'h12);
    wait_st(closed_st); // tied input
    check(rv[12], 1'b1); // tie reads back
    bus(1'b0, CTRL_OFS, 32'h0);
    check(rv, 32'h10); // tie in control
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    check(rv[3:0], 4'h2); // no blocked event
    jam <= 1'b0;
    $display("done: tied torque input");
    slow <= 1'b1;
    bus(1'b1, CTRL_OFS, 32'h1);
    repeat (40) @(posedge mclk_i);
    bus(1'b1, CTRL_OFS, 32'h2);
    #1;
    check({m_op, m_cl}, 2'b01); // reverse to closing
    wait_st(closed_st); // slow closed end
    check({m_cl, l_cl, f_cl}, 3'b001); // drive off
    $display("done: reverse at slow travel");
    finish_test();
  end
endmodule
